// *** verilog/ulms_pkg.sv ***
// Constants shared by the line and modem status block.
package ulms_pkg;
    // Register word addresses on the plain port.
    localparam logic [2:0] ADDR_RX_TX = 3'h0;
    localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h1;
    localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
    localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
    localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
    // Line status bit positions.
    localparam int LS_READY = 0;
    localparam int LS_OVERRUN = 1;
    localparam int LS_PARITY = 2;
    localparam int LS_FRAMING = 3;
    localparam int LS_BREAK = 4;
    localparam int LS_HOLD_EMPTY = 5;
    localparam int LS_TX_EMPTY = 6;
    // Modem control bit positions.
    localparam int MC_TERM_READY = 0;
    localparam int MC_REQ_SEND = 1;
    localparam int MC_USER_OUT1 = 2;
    localparam int MC_USER_OUT2 = 3;
    localparam int MC_LOOPBACK = 4;
    localparam int MC_WIDTH = 5;
    // Modem status positions: change bits low, states high.
    localparam int MS_CTS = 0;
    localparam int MS_DSR = 1;
    localparam int MS_RING = 2;
    localparam int MS_DCD = 3;
    localparam int MS_STATE = 4;
    // Interrupt enable bit positions.
    localparam int IE_RX_DATA = 0;
    localparam int IE_HOLD_EMPTY = 1;
    localparam int IE_LINE = 2;
    localparam int IE_MODEM = 3;
    localparam int IE_WIDTH = 4;
    // Reset values.
    localparam logic [4:0] MC_RESET = 5'h00;
    localparam logic [3:0] IE_RESET = 4'h0;
    localparam logic [3:0] PIN_IDLE_N = 4'hf;
    // Interrupt identification codes, priority one to four.
    localparam logic [2:0] ID_NONE = 3'h1;
    localparam logic [2:0] ID_LINE = 3'h6;
    localparam logic [2:0] ID_RX_DATA = 3'h4;
    localparam logic [2:0] ID_HOLD = 3'h2;
    localparam logic [2:0] ID_MODEM = 3'h0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// *** verilog/ulms_core.sv ***
// Line status, modem control and modem status logic of the serial element.
//
// Notes on behaviour
// - Receive-ready sets when a character lands in the buffer, clears on buffer read.
// - Overrun sets when an unread character is replaced; line status read clears it.
// - Parity error sets on parity mismatch; line status read clears it.
// - Framing error sets on missing high stop bit; line status read clears it.
// - Break sets when input stays low over a character time; read clears it.
// - Overrun, parity, framing and break flags form the line status interrupt.
// - Holding-empty sets when holding passes to shifter, clears on host load.
// - Transmitter-empty reads set only while holding and shifter are both empty.
// - Line status bit 7 always reads zero.
// - Control bits 0 and 1 drive terminal-ready and request-to-send low.
// - Control bit 3 gates the interrupt output.
// - Control bit 2 drives spare output user_out1_n low, or feeds ring in loopback.
// - Loopback holds serial output high and feeds transmit into receive.
// - Loopback ignores modem pins, forces outputs high, feeds control bits back.
// - In loopback all interrupts work; control bits act as modem sources.
// - Control bits 5 to 7 always read zero.
// - Reading modem status clears all four change bits.
// - Change bits 0, 1, 3 set when their input changed since last read.
// - Change bit 2 sets on the trailing edge of ring.
// - Any change bit with modem interrupt enabled raises the modem interrupt.
// - Status bits 4 to 7 show inverted inputs, or control bits in loopback.
// - Line status interrupt has top priority and clears on line status read.
// - Modem interrupt has lowest priority and clears on modem status read.
// - Enable bit 2 permits line interrupt, bit 3 permits modem interrupt.
`timescale 1ns/1ps

module ulms_core (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Receiver side.
    input wire logic [7:0] rx_char,
    input wire logic rx_char_stored,
    input wire logic rx_parity_fail,
    input wire logic rx_frame_fail,
    input wire logic rx_line_low_long,
    output logic rx_serial,
    // Transmitter side.
    input wire logic tx_holding_taken,
    input wire logic tx_shift_busy,
    input wire logic tx_serial,
    output logic tx_load,
    output logic [7:0] tx_char,
    // Serial pins.
    input wire logic serial_input,
    output logic serial_output,
    // Modem pins, active low.
    input wire logic clear_to_send_n,
    input wire logic set_ready_n,
    input wire logic ring_n,
    input wire logic carrier_detect_input_n,
    output logic terminal_ready_n,
    output logic request_send_n,
    output logic user_out1_n,
    output logic user_out2_n,
    // Interrupt.
    output logic irq,
    output logic [2:0] irq_id
);

    logic [ulms_pkg::MC_WIDTH-1:0] modem_control_r;
    logic [ulms_pkg::IE_WIDTH-1:0] irq_enable_r;
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    logic [3:0] state_prev_r;
    logic [3:0] state_now;
    logic [3:0] change_r;
    logic [3:0] change_evt;
    logic ready_r;
    logic overrun_r;
    logic parity_r;
    logic framing_r;
    logic break_r;
    logic hold_empty_r;
    logic tx_empty;
    logic loop;
    logic rd_rx;
    logic rd_line;
    logic rd_modem;
    logic wr_line;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [7:0] rdata_nxt;
    logic int_line;
    logic int_rx;
    logic int_hold;
    logic int_modem;
    logic [2:0] irq_id_nxt;

    // Address decode shared by the read and write paths.
    function automatic logic hit(
        input logic strobe,
        input logic [2:0] a,
        input logic [2:0] target
    );
        hit = strobe && (a == target);
    endfunction

    assign loop = modem_control_r[ulms_pkg::MC_LOOPBACK];
    assign rd_rx = hit(rd, addr, ulms_pkg::ADDR_RX_TX);
    assign rd_line = hit(rd, addr, ulms_pkg::ADDR_LINE_STATUS);
    assign rd_modem = hit(rd, addr, ulms_pkg::ADDR_MODEM_STATUS);
    assign wr_line = hit(wr, addr, ulms_pkg::ADDR_LINE_STATUS);

    // Control registers written by the host.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modem_control_r <= ulms_pkg::MC_RESET;
        end else if (hit(wr, addr, ulms_pkg::ADDR_MODEM_CONTROL)) begin
            modem_control_r <= wdata[ulms_pkg::MC_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_enable_r <= ulms_pkg::IE_RESET;
        end else if (hit(wr, addr, ulms_pkg::ADDR_IRQ_ENABLE)) begin
            irq_enable_r <= wdata[ulms_pkg::IE_WIDTH-1:0];
        end
    end

    // Receive-ready: a new character wins over a same-cycle buffer read.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_r <= 1'b0;
        end else if (rx_char_stored) begin
            ready_r <= 1'b1;
        end else if (rd_rx) begin
            ready_r <= 1'b0;
        end
    end

    // Error flags: set wins over the clearing line status read.
    // A factory-test write to line status may force an error flag.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overrun_r <= 1'b0;
        end else if (rx_char_stored && ready_r && !rd_rx) begin
            overrun_r <= 1'b1;
        end else if (wr_line) begin
            overrun_r <= wdata[ulms_pkg::LS_OVERRUN];
        end else if (rd_line) begin
            overrun_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            parity_r <= 1'b0;
        end else if (rx_parity_fail) begin
            parity_r <= 1'b1;
        end else if (wr_line) begin
            parity_r <= wdata[ulms_pkg::LS_PARITY];
        end else if (rd_line) begin
            parity_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            framing_r <= 1'b0;
        end else if (rx_frame_fail) begin
            framing_r <= 1'b1;
        end else if (wr_line) begin
            framing_r <= wdata[ulms_pkg::LS_FRAMING];
        end else if (rd_line) begin
            framing_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            break_r <= 1'b0;
        end else if (rx_line_low_long) begin
            break_r <= 1'b1;
        end else if (wr_line) begin
            break_r <= wdata[ulms_pkg::LS_BREAK];
        end else if (rd_line) begin
            break_r <= 1'b0;
        end
    end

    // Holding-empty: the transfer to the shifter wins over a host load.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_empty_r <= 1'b1;
        end else if (tx_holding_taken) begin
            hold_empty_r <= 1'b1;
        end else if (hit(wr, addr, ulms_pkg::ADDR_RX_TX)) begin
            hold_empty_r <= 1'b0;
        end
    end

    // Host load handed to the transmitter as a one-cycle pulse.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_load <= 1'b0;
            tx_char <= ulms_pkg::ZERO_BYTE;
        end else begin
            tx_load <= hit(wr, addr, ulms_pkg::ADDR_RX_TX);
            if (hit(wr, addr, ulms_pkg::ADDR_RX_TX)) begin
                tx_char <= wdata;
            end
        end
    end

    assign tx_empty = hold_empty_r && !tx_shift_busy;

    always_comb begin
        line_status = ulms_pkg::ZERO_BYTE;
        line_status[ulms_pkg::LS_READY] = ready_r;
        line_status[ulms_pkg::LS_OVERRUN] = overrun_r;
        line_status[ulms_pkg::LS_PARITY] = parity_r;
        line_status[ulms_pkg::LS_FRAMING] = framing_r;
        line_status[ulms_pkg::LS_BREAK] = break_r;
        line_status[ulms_pkg::LS_HOLD_EMPTY] = hold_empty_r;
        line_status[ulms_pkg::LS_TX_EMPTY] = tx_empty;
    end

    // Two-stage synchroniser on the active-low modem pins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta_r <= ulms_pkg::PIN_IDLE_N;
            pin_sync_r <= ulms_pkg::PIN_IDLE_N;
        end else begin
            pin_meta_r[ulms_pkg::MS_CTS] <= clear_to_send_n;
            pin_meta_r[ulms_pkg::MS_DSR] <= set_ready_n;
            pin_meta_r[ulms_pkg::MS_RING] <= ring_n;
            pin_meta_r[ulms_pkg::MS_DCD] <= carrier_detect_input_n;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Asserted modem line states, from pins or looped control bits.
    always_comb begin
        if (loop) begin
            state_now[ulms_pkg::MS_CTS] = modem_control_r[ulms_pkg::MC_REQ_SEND];
            state_now[ulms_pkg::MS_DSR] = modem_control_r[ulms_pkg::MC_TERM_READY];
            state_now[ulms_pkg::MS_RING] = modem_control_r[ulms_pkg::MC_USER_OUT1];
            state_now[ulms_pkg::MS_DCD] = modem_control_r[ulms_pkg::MC_USER_OUT2];
        end else begin
            state_now = ~pin_sync_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_prev_r <= ~ulms_pkg::PIN_IDLE_N;
        end else begin
            state_prev_r <= state_now;
        end
    end

    // Change events; ring counts only its trailing edge.
    always_comb begin
        change_evt = state_now ^ state_prev_r;
        change_evt[ulms_pkg::MS_RING] = state_prev_r[ulms_pkg::MS_RING]
            && !state_now[ulms_pkg::MS_RING];
    end

    // Change bits: a new event survives a same-cycle status read.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_change
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    change_r[gi] <= 1'b0;
                end else if (change_evt[gi]) begin
                    change_r[gi] <= 1'b1;
                end else if (rd_modem) begin
                    change_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign modem_status = {state_now, change_r};

    // Read data stands in the cycle after the strobe only.
    always_comb begin
        rdata_nxt = ulms_pkg::ZERO_BYTE;
        if (rd) begin
            case (addr)
                ulms_pkg::ADDR_RX_TX: rdata_nxt = rx_char;
                ulms_pkg::ADDR_IRQ_ENABLE: rdata_nxt = {4'h0, irq_enable_r};
                ulms_pkg::ADDR_MODEM_CONTROL: rdata_nxt = {3'h0, modem_control_r};
                ulms_pkg::ADDR_LINE_STATUS: rdata_nxt = line_status;
                ulms_pkg::ADDR_MODEM_STATUS: rdata_nxt = modem_status;
                default: rdata_nxt = ulms_pkg::ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= ulms_pkg::ZERO_BYTE;
        end else begin
            rdata <= rdata_nxt;
        end
    end

    // Serial path and loopback.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_output <= 1'b1;
            rx_serial <= 1'b1;
        end else begin
            serial_output <= loop ? 1'b1 : tx_serial;
            rx_serial <= loop ? tx_serial : serial_input;
        end
    end

    // Modem outputs: a set bit drives its pin low, loopback holds all high.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            terminal_ready_n <= 1'b1;
            request_send_n <= 1'b1;
            user_out1_n <= 1'b1;
            user_out2_n <= 1'b1;
        end else begin
            terminal_ready_n <= loop || !modem_control_r[ulms_pkg::MC_TERM_READY];
            request_send_n <= loop || !modem_control_r[ulms_pkg::MC_REQ_SEND];
            user_out1_n <= loop || !modem_control_r[ulms_pkg::MC_USER_OUT1];
            user_out2_n <= loop || !modem_control_r[ulms_pkg::MC_USER_OUT2];
        end
    end

    // Interrupt sources, each gated by its enable bit.
    assign int_line = irq_enable_r[ulms_pkg::IE_LINE]
        && (overrun_r || parity_r || framing_r || break_r);
    assign int_rx = irq_enable_r[ulms_pkg::IE_RX_DATA] && ready_r;
    assign int_hold = irq_enable_r[ulms_pkg::IE_HOLD_EMPTY] && hold_empty_r;
    assign int_modem = irq_enable_r[ulms_pkg::IE_MODEM] && (|change_r);

    always_comb begin
        if (int_line) begin
            irq_id_nxt = ulms_pkg::ID_LINE;
        end else if (int_rx) begin
            irq_id_nxt = ulms_pkg::ID_RX_DATA;
        end else if (int_hold) begin
            irq_id_nxt = ulms_pkg::ID_HOLD;
        end else if (int_modem) begin
            irq_id_nxt = ulms_pkg::ID_MODEM;
        end else begin
            irq_id_nxt = ulms_pkg::ID_NONE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
            irq_id <= ulms_pkg::ID_NONE;
        end else begin
            irq <= modem_control_r[ulms_pkg::MC_USER_OUT2]
                && (int_line || int_rx || int_hold || int_modem);
            irq_id <= irq_id_nxt;
        end
    end

endmodule // ulms_core

// *** sim/ulms_core_properties.sv ***
// Concurrent checks on the ports of the line and modem status block.
`timescale 1ns/1ps
module ulms_core_properties (
    // Clock, reset and register port.
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Receiver and transmitter events.
    input wire logic rx_char_stored,
    input wire logic rx_parity_fail,
    input wire logic rx_frame_fail,
    input wire logic rx_line_low_long,
    input wire logic tx_holding_taken,
    input wire logic tx_shift_busy,
    // Pins and interrupt.
    input wire logic serial_output,
    input wire logic clear_to_send_n,
    input wire logic set_ready_n,
    input wire logic ring_n,
    input wire logic carrier_detect_input_n,
    input wire logic terminal_ready_n,
    input wire logic request_send_n,
    input wire logic user_out1_n,
    input wire logic user_out2_n,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic rd_ls = rd && addr == ulms_pkg::ADDR_LINE_STATUS;
    wire logic rd_ms = rd && addr == ulms_pkg::ADDR_MODEM_STATUS;
    wire logic wr_mc = wr && addr == ulms_pkg::ADDR_MODEM_CONTROL;
    wire logic rx_ev = rx_char_stored || rx_parity_fail || rx_frame_fail || rx_line_low_long;
    wire logic [3:0] pins = {clear_to_send_n, set_ready_n, ring_n, carrier_detect_input_n};
    sequence s_ls_read; rd_ls && !rx_ev; endsequence
    sequence s_quiet; $stable(pins) && !wr_mc; endsequence
    sequence s_ms_read; rd_ms && $stable(pins) && !wr_mc; endsequence
    property p_ls_bit7; rd_ls |=> !rdata[7]; endproperty
    a_ls_bit7: assert property (p_ls_bit7) else $error("line status bit 7 set");
    property p_mc_top; rd && addr == ulms_pkg::ADDR_MODEM_CONTROL |=> rdata[7:5] == 3'h0; endproperty
    a_mc_top: assert property (p_mc_top) else $error("modem control top bits set");
    property p_ls_clear; s_ls_read ##1 s_ls_read |=> rdata[4:1] == 4'h0; endproperty
    a_ls_clear: assert property (p_ls_clear) else $error("error flags survive read");
    property p_ms_clear; s_quiet [*6] ##1 s_ms_read ##1 rd_ms |=> rdata[3:0] == 4'h0; endproperty
    a_ms_clear: assert property (p_ms_clear) else $error("change bits survive read");
    property p_hold;
        wr && addr == ulms_pkg::ADDR_RX_TX && !tx_holding_taken ##1 !tx_holding_taken ##1 rd_ls |=> !rdata[5];
    endproperty
    a_hold: assert property (p_hold) else $error("holding empty after load");
    property p_transmitter_empty_flag_hold; rd_ls |=> !(rdata[6] && !rdata[5]); endproperty
    a_transmitter_empty_flag_hold: assert property (p_transmitter_empty_flag_hold) else $error("tx empty with holding full");
    property p_transmitter_empty_flag_busy; rd_ls && tx_shift_busy && $past(tx_shift_busy) |=> !rdata[6]; endproperty
    a_transmitter_empty_flag_busy: assert property (p_transmitter_empty_flag_busy) else $error("tx empty while shifting");
    property p_dtr;
        wr_mc && !wdata[4] |=> ##1 terminal_ready_n == !$past(wdata[0], 2) && request_send_n == !$past(wdata[1], 2);
    endproperty
    a_dtr: assert property (p_dtr) else $error("modem outputs wrong");
    property p_loop;
        wr_mc && wdata[4] |=> ##1 serial_output && terminal_ready_n && request_send_n && user_out1_n && user_out2_n;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback outputs not high");
    property p_irq_gate; wr_mc && !wdata[3] ##1 !wr_mc |=> !irq; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");
endmodule // ulms_core_properties

// *** sim/ulms_modem_model.sv ***
// Modem model: answers the block's ready and request outputs.
`timescale 1ns/1ps
module ulms_modem_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Block outputs and bench wishes.
    input wire logic terminal_ready_n,
    input wire logic request_send_n,
    input wire logic slow,
    input wire logic ring_on,
    input wire logic carrier_on,
    // Pins back to the block.
    output logic clear_to_send_n,
    output logic set_ready_n,
    output logic ring_n,
    output logic carrier_detect_input_n
);
    logic [3:0] wait_r;
    // Clear-to-send follows request-to-send at once, or after a delay when slow.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_r <= 4'h0;
            clear_to_send_n <= 1'b1;
        end else if (request_send_n == clear_to_send_n) begin
            wait_r <= 4'h0;
        end else if (!slow || wait_r == 4'h7) begin
            clear_to_send_n <= request_send_n;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {set_ready_n, ring_n, carrier_detect_input_n} <= 3'h7;
        end else begin
            {set_ready_n, ring_n, carrier_detect_input_n} <= {terminal_ready_n, !ring_on, !carrier_on};
        end
    end
endmodule // ulms_modem_model

// *** sim/ulms_core_bench.sv ***
// Self-checking bench for the line and modem status block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("mismatch at %0t: %h not %h", $time, g, e); end end
module ulms_core_bench;
    logic clk, rst, wr, rd, slow, ring_on, carrier_on, tx_shift_busy, tx_serial, serial_input, irq, rx_serial;
    logic serial_output, clear_to_send_n, set_ready_n, ring_n, carrier_detect_input_n;
    logic terminal_ready_n, request_send_n, user_out1_n, user_out2_n, tx_load;
    logic [2:0] addr, irq_id;
    logic [7:0] wdata, rdata, rx_char, tx_char;
    logic [4:0] ev;
    int mismatches = 0;
    int n_tests = 0;
    ulms_core i_dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .rx_char, .rx_char_stored(ev[4]),
        .rx_parity_fail(ev[3]), .rx_frame_fail(ev[2]), .rx_line_low_long(ev[1]), .rx_serial,
        .tx_holding_taken(ev[0]), .tx_shift_busy, .tx_serial, .tx_load, .tx_char, .serial_input,
        .serial_output, .clear_to_send_n, .set_ready_n, .ring_n, .carrier_detect_input_n,
        .terminal_ready_n, .request_send_n, .user_out1_n, .user_out2_n, .irq, .irq_id);
    ulms_modem_model i_modem (.clk, .rst, .terminal_ready_n, .request_send_n, .slow, .ring_on, .carrier_on,
        .clear_to_send_n, .set_ready_n, .ring_n, .carrier_detect_input_n);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        @(negedge clk) `CHK(rdata, e)
    endtask
    task automatic rls(input logic [7:0] e);
        rd_reg(ulms_pkg::ADDR_LINE_STATUS, e);
    endtask
    // Two reads on consecutive cycles.
    task automatic rd2(input logic [2:0] a, input logic [7:0] e1, input logic [7:0] e2);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk);
        @(negedge clk) `CHK(rdata, e1)
        @(posedge clk) rd <= 1'b0;
        @(negedge clk) `CHK(rdata, e2)
    endtask
    task automatic pulse(input logic [4:0] e);
        @(posedge clk) ev <= e;
        @(posedge clk) ev <= 5'h00;
    endtask
    task automatic test_done;
        $display("%0d checks, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        test_done;
    end
    initial begin
        {rst, wr, rd, slow, ring_on, carrier_on, tx_shift_busy, tx_serial, serial_input} = 9'h103;
        {addr, wdata, ev, rx_char} = {3'h0, 8'h00, 5'h00, 8'h5a};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rls(8'h60);
        rd_reg(ulms_pkg::ADDR_MODEM_STATUS, 8'h00);
        `CHK({serial_output, terminal_ready_n, request_send_n, user_out1_n, user_out2_n}, 5'h1f)
        $display("test reset done");
        wr_reg(ulms_pkg::ADDR_IRQ_ENABLE, 8'h05);
        wr_reg(ulms_pkg::ADDR_MODEM_CONTROL, 8'h08);
        pulse(5'h10);
        pulse(5'h10);
        cyc(2);
        `CHK(irq_id, ulms_pkg::ID_LINE)
        rd2(ulms_pkg::ADDR_LINE_STATUS, 8'h63, 8'h61);
        `CHK(irq_id, ulms_pkg::ID_RX_DATA)
        rd_reg(ulms_pkg::ADDR_RX_TX, 8'h5a);
        rls(8'h60);
        for (int i = 0; i < 3; i++) begin
            pulse(5'h08 >> i);
            cyc(2);
            `CHK(irq, 1'b1)
            rd2(ulms_pkg::ADDR_LINE_STATUS, 8'h04 << i | 8'h60, 8'h60);
            `CHK(irq, 1'b0)
        end
        wr_reg(ulms_pkg::ADDR_MODEM_CONTROL, 8'h00);
        pulse(5'h08);
        cyc(2);
        `CHK(irq, 1'b0)
        wr_reg(ulms_pkg::ADDR_MODEM_CONTROL, 8'h08);
        cyc(2);
        `CHK(irq, 1'b1)
        rls(8'h64);
        wr_reg(ulms_pkg::ADDR_IRQ_ENABLE, 8'h00);
        pulse(5'h04);
        cyc(2);
        `CHK(irq, 1'b0)
        rls(8'h68);
        $display("test line status done");
        wr_reg(ulms_pkg::ADDR_RX_TX, 8'ha5);
        @(negedge clk) `CHK(tx_load, 1'b1)
        rls(8'h00);
        `CHK({tx_load, tx_char}, {1'b0, 8'ha5})
        @(posedge clk) tx_shift_busy <= 1'b1;
        pulse(5'h01);
        rls(8'h20);
        @(posedge clk) tx_shift_busy <= 1'b0;
        rls(8'h60);
        wr_reg(ulms_pkg::ADDR_IRQ_ENABLE, 8'h02);
        cyc(2);
        `CHK(irq_id, ulms_pkg::ID_HOLD)
        wr_reg(ulms_pkg::ADDR_RX_TX, 8'h3c);
        cyc(2);
        `CHK(irq, 1'b0)
        pulse(5'h01);
        $display("test transmit done");
        @(posedge clk) slow <= 1'b1;
        wr_reg(ulms_pkg::ADDR_MODEM_CONTROL, 8'h03);
        cyc(2);
        `CHK({terminal_ready_n, request_send_n}, 2'b00)
        cyc(20);
        rd2(ulms_pkg::ADDR_MODEM_STATUS, 8'h33, 8'h30);
        @(posedge clk) carrier_on <= 1'b1;
        cyc(8);
        rd_reg(ulms_pkg::ADDR_MODEM_STATUS, 8'hb8);
        @(posedge clk) ring_on <= 1'b1;
        cyc(8);
        rd_reg(ulms_pkg::ADDR_MODEM_STATUS, 8'hf0);
        @(posedge clk) ring_on <= 1'b0;
        cyc(8);
        rd_reg(ulms_pkg::ADDR_MODEM_STATUS, 8'hb4);
        wr_reg(ulms_pkg::ADDR_IRQ_ENABLE, 8'h08);
        wr_reg(ulms_pkg::ADDR_MODEM_CONTROL, 8'h0b);
        @(posedge clk) carrier_on <= 1'b0;
        cyc(8);
        `CHK({irq, irq_id}, {1'b1, ulms_pkg::ID_MODEM})
        rd_reg(ulms_pkg::ADDR_MODEM_STATUS, 8'h38);
        cyc(1);
        `CHK(irq, 1'b0)
        $display("test modem done");
        wr_reg(ulms_pkg::ADDR_MODEM_CONTROL, 8'h1f);
        cyc(2);
        `CHK({serial_output, terminal_ready_n, request_send_n, user_out1_n, user_out2_n}, 5'h1f)
        cyc(8);
        rd_reg(ulms_pkg::ADDR_MODEM_STATUS, 8'hf8);
        wr_reg(ulms_pkg::ADDR_MODEM_CONTROL, 8'h12);
        cyc(8);
        rd_reg(ulms_pkg::ADDR_MODEM_STATUS, 8'h1e);
        @(posedge clk) {tx_serial, serial_input} <= 2'b01;
        cyc(2);
        `CHK({rx_serial, serial_output}, 2'b01)
        @(posedge clk) {tx_serial, serial_input} <= 2'b10;
        cyc(2);
        `CHK(rx_serial, 1'b1)
        wr_reg(ulms_pkg::ADDR_MODEM_CONTROL, 8'h00);
        @(posedge clk) {tx_serial, serial_input} <= 2'b01;
        cyc(2);
        `CHK({rx_serial, serial_output}, 2'b10)
        @(posedge clk) {tx_serial, serial_input} <= 2'b11;
        $display("test loopback done");
        wr_reg(ulms_pkg::ADDR_LINE_STATUS, 8'hff);
        rd2(ulms_pkg::ADDR_LINE_STATUS, 8'h7e, 8'h60);
        wr_reg(3'h7, 8'hff);
        rd_reg(3'h7, 8'h00);
        wr_reg(ulms_pkg::ADDR_MODEM_CONTROL, 8'he0);
        rd_reg(ulms_pkg::ADDR_MODEM_CONTROL, 8'h00);
        $display("test registers done");
        test_done;
    end
endmodule // ulms_core_bench
bind ulms_core ulms_core_properties u_props (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .rx_char_stored,
    .rx_parity_fail, .rx_frame_fail, .rx_line_low_long, .tx_holding_taken, .tx_shift_busy, .serial_output,
    .clear_to_send_n, .set_ready_n, .ring_n, .carrier_detect_input_n, .terminal_ready_n, .request_send_n,
    .user_out1_n, .user_out2_n, .irq);
